// *** rtl/smoe_defines.svh ***
`ifndef SMOE_DEFINES_SVH
`define SMOE_DEFINES_SVH
`define SMOE_ADDR_SEL_HI  7'h69
`define SMOE_ADDR_SEL_LO  7'h6e
`define SMOE_OFF_THR      5'h16
`define SMOE_OFF_PAIR     5'h17
`define SMOE_RST_THR      8'h0f
`define SMOE_RST_PAIR     8'hff
`define SMOE_RST_CTL      16'h3fff
`define SMOE_RST_SYNC     3'h6
`define SMOE_BITS_PER_BYTE 4'h8
`define SMOE_THR_HI       7
`define SMOE_THR_LO       6
`define SMOE_FB_A         5
`define SMOE_FB_B         4
`define SMOE_B2           1
`define SMOE_B1           7
`define SMOE_B0           6
`define SMOE_A2           5
`define SMOE_A1           3
`define SMOE_A0           2
`define SMOE_CMD_BYTE_BIT 7
`endif

// *** rtl/smoe_pkg.sv ***
package smoe_pkg;
  typedef enum logic [8:0] {
    SMOE_IDLE  = 9'h001,
    SMOE_ADDR  = 9'h002,
    SMOE_ACK_A = 9'h004,
    SMOE_CMD   = 9'h008,
    SMOE_ACK_C = 9'h010,
    SMOE_WDATA = 9'h020,
    SMOE_ACK_D = 9'h040,
    SMOE_RDATA = 9'h080,
    SMOE_RACK  = 9'h100
  } smoe_fsm_t;

  typedef struct packed {
    logic [1:0] threshold_sel;
    logic       feedback_out_bank_a_en;
    logic       feedback_out_bank_b_en;
    logic       bank_b_pair2_true_en;
    logic       bank_b_pair2_comp_en;
    logic       bank_b_pair1_true_en;
    logic       bank_b_pair1_comp_en;
    logic       bank_b_pair0_true_en;
    logic       bank_b_pair0_comp_en;
    logic       bank_a_pair2_true_en;
    logic       bank_a_pair2_comp_en;
    logic       bank_a_pair1_true_en;
    logic       bank_a_pair1_comp_en;
    logic       bank_a_pair0_true_en;
    logic       bank_a_pair0_comp_en;
  } smoe_out_t;

  typedef struct packed {
    smoe_fsm_t  fsm;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic       rw;
    logic [4:0] offset;
    logic [7:0] wbyte;
    logic       wr_pend;
    logic       sda_oe;
    logic       touched;
    logic [7:0] thr_fb;
    logic [7:0] pair_en;
    smoe_out_t  ctl;
  } smoe_st_t;
endpackage : smoe_pkg

// *** rtl/smoe_sync.sv ***
`timescale 1ns/1ps
module smoe_sync #(
  parameter int          W   = 3,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST;
      q       <= RST;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : smoe_sync

// *** rtl/smoe_top.sv ***
`timescale 1ns/1ps
`include "smoe_defines.svh"
module smoe_top (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  input  wire logic         addr_sel,
  output logic              sda_out,
  output logic              sda_oe,
  output smoe_pkg::smoe_out_t clk_ctl
);
  smoe_pkg::smoe_st_t st_ff;
  smoe_pkg::smoe_st_t nxt_st;
  logic [2:0]         sync_q;
  logic               scl_s;
  logic               sda_s;
  logic               sel_s;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_det;
  logic               stop_det;
  logic [6:0]         my_addr;
  logic [7:0]         rd_byte;
  logic               byte_done;

  smoe_sync #(
    .W   (3),
    .RST (`SMOE_RST_SYNC)
  ) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d      ({scl_in, sda_in, addr_sel}),
    .q      (sync_q)
  );

  assign scl_s     = sync_q[2];
  assign sda_s     = sync_q[1];
  assign sel_s     = sync_q[0];
  // The link clock is oversampled, so its edges are found by comparison.
  assign scl_rise  = scl_s & ~st_ff.scl_q;
  assign scl_fall  = ~scl_s & st_ff.scl_q;
  assign start_det = scl_s & st_ff.scl_q & st_ff.sda_q & ~sda_s;
  assign stop_det  = scl_s & st_ff.scl_q & ~st_ff.sda_q & sda_s;
  assign my_addr   = sel_s ? `SMOE_ADDR_SEL_HI : `SMOE_ADDR_SEL_LO;
  assign byte_done = (st_ff.cnt == `SMOE_BITS_PER_BYTE);
  // Offsets without storage read as zero and ignore writes.
  assign rd_byte   = (st_ff.offset == `SMOE_OFF_THR)  ? st_ff.thr_fb  :
                     (st_ff.offset == `SMOE_OFF_PAIR) ? st_ff.pair_en : 8'h00;

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.scl_q = scl_s;
    nxt_st.sda_q = sda_s;
    if (stop_det) begin
      if (st_ff.wr_pend) begin
        nxt_st.touched = 1'b1;
        if (st_ff.offset == `SMOE_OFF_THR) begin
          nxt_st.thr_fb = st_ff.wbyte;
        end
        if (st_ff.offset == `SMOE_OFF_PAIR) begin
          nxt_st.pair_en = st_ff.wbyte;
        end
      end
      nxt_st.wr_pend = 1'b0;
      nxt_st.sda_oe  = 1'b0;
      nxt_st.fsm     = smoe_pkg::SMOE_IDLE;
    end else if (start_det) begin
      // A repeated start keeps the offset so a read can follow the command.
      nxt_st.fsm     = smoe_pkg::SMOE_ADDR;
      nxt_st.cnt     = 4'h0;
      nxt_st.sda_oe  = 1'b0;
      nxt_st.wr_pend = 1'b0;
    end else if (scl_rise) begin
      case (st_ff.fsm)
        smoe_pkg::SMOE_ADDR, smoe_pkg::SMOE_CMD, smoe_pkg::SMOE_WDATA: begin
          nxt_st.shreg = {st_ff.shreg[6:0], sda_s};
          nxt_st.cnt   = st_ff.cnt + 4'h1;
        end
        smoe_pkg::SMOE_RDATA: begin
          nxt_st.cnt = st_ff.cnt + 4'h1;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_ff.fsm)
        smoe_pkg::SMOE_ADDR: begin
          if (byte_done) begin
            if (st_ff.shreg[7:1] == my_addr) begin
              nxt_st.rw     = st_ff.shreg[0];
              nxt_st.sda_oe = 1'b1;
              nxt_st.fsm    = smoe_pkg::SMOE_ACK_A;
            end else begin
              nxt_st.fsm = smoe_pkg::SMOE_IDLE;
            end
          end
        end
        smoe_pkg::SMOE_ACK_A: begin
          nxt_st.cnt = 4'h0;
          if (st_ff.rw) begin
            nxt_st.shreg  = rd_byte;
            nxt_st.sda_oe = ~rd_byte[7];
            nxt_st.fsm    = smoe_pkg::SMOE_RDATA;
          end else begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.fsm    = smoe_pkg::SMOE_CMD;
          end
        end
        smoe_pkg::SMOE_CMD: begin
          if (byte_done) begin
            // Block mode is not served, so its command is left unanswered.
            if (st_ff.shreg[`SMOE_CMD_BYTE_BIT]) begin
              nxt_st.offset = st_ff.shreg[4:0];
              nxt_st.sda_oe = 1'b1;
              nxt_st.fsm    = smoe_pkg::SMOE_ACK_C;
            end else begin
              nxt_st.fsm = smoe_pkg::SMOE_IDLE;
            end
          end
        end
        smoe_pkg::SMOE_ACK_C: begin
          nxt_st.sda_oe = 1'b0;
          nxt_st.cnt    = 4'h0;
          nxt_st.fsm    = smoe_pkg::SMOE_WDATA;
        end
        smoe_pkg::SMOE_WDATA: begin
          if (byte_done) begin
            nxt_st.wbyte   = st_ff.shreg;
            nxt_st.wr_pend = 1'b1;
            nxt_st.sda_oe  = 1'b1;
            nxt_st.fsm     = smoe_pkg::SMOE_ACK_D;
          end
        end
        smoe_pkg::SMOE_ACK_D: begin
          nxt_st.sda_oe = 1'b0;
          nxt_st.fsm    = smoe_pkg::SMOE_IDLE;
        end
        smoe_pkg::SMOE_RDATA: begin
          if (byte_done) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.fsm    = smoe_pkg::SMOE_RACK;
          end else begin
            nxt_st.shreg  = {st_ff.shreg[6:0], 1'b0};
            nxt_st.sda_oe = ~st_ff.shreg[6];
          end
        end
        smoe_pkg::SMOE_RACK: begin
          nxt_st.fsm = smoe_pkg::SMOE_IDLE;
        end
        default: begin
          nxt_st.fsm = smoe_pkg::SMOE_IDLE;
        end
      endcase
    end
    // Controls leave a register so the clock pins never see decode glitches.
    nxt_st.ctl.threshold_sel          = nxt_st.thr_fb[`SMOE_THR_HI:`SMOE_THR_LO];
    nxt_st.ctl.feedback_out_bank_a_en = ~nxt_st.thr_fb[`SMOE_FB_A];
    nxt_st.ctl.feedback_out_bank_b_en = ~nxt_st.thr_fb[`SMOE_FB_B];
    nxt_st.ctl.bank_b_pair2_true_en   = nxt_st.thr_fb[`SMOE_B2];
    nxt_st.ctl.bank_b_pair2_comp_en   = nxt_st.thr_fb[`SMOE_B2];
    nxt_st.ctl.bank_b_pair1_true_en   = nxt_st.pair_en[`SMOE_B1];
    nxt_st.ctl.bank_b_pair1_comp_en   = nxt_st.pair_en[`SMOE_B1];
    nxt_st.ctl.bank_b_pair0_true_en   = nxt_st.pair_en[`SMOE_B0];
    nxt_st.ctl.bank_b_pair0_comp_en   = nxt_st.pair_en[`SMOE_B0];
    nxt_st.ctl.bank_a_pair2_true_en   = nxt_st.pair_en[`SMOE_A2];
    nxt_st.ctl.bank_a_pair2_comp_en   = nxt_st.pair_en[`SMOE_A2];
    nxt_st.ctl.bank_a_pair1_true_en   = nxt_st.pair_en[`SMOE_A1];
    nxt_st.ctl.bank_a_pair1_comp_en   = nxt_st.pair_en[`SMOE_A1];
    nxt_st.ctl.bank_a_pair0_true_en   = nxt_st.pair_en[`SMOE_A0];
    nxt_st.ctl.bank_a_pair0_comp_en   = nxt_st.pair_en[`SMOE_A0];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff         <= '0;
      st_ff.fsm     <= smoe_pkg::SMOE_IDLE;
      st_ff.scl_q   <= 1'b1;
      st_ff.sda_q   <= 1'b1;
      st_ff.thr_fb  <= `SMOE_RST_THR;
      st_ff.pair_en <= `SMOE_RST_PAIR;
      st_ff.ctl     <= `SMOE_RST_CTL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The pin only ever pulls low; the enable carries the data.
  assign sda_out = 1'b0;
  assign sda_oe  = st_ff.sda_oe;
  assign clk_ctl = st_ff.ctl;

  sequence s_addr_end;
    st_ff.fsm == smoe_pkg::SMOE_ADDR && byte_done && scl_fall && !stop_det && !start_det;
  endsequence

  a_addr_match_ack: assert property (@(posedge mclk) disable iff (!arst_n)
    s_addr_end and (st_ff.shreg[7:1] == my_addr) |=> st_ff.sda_oe && st_ff.fsm == smoe_pkg::SMOE_ACK_A)
    else $error("Matching address not acknowledged.");
  a_addr_miss_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    s_addr_end and (st_ff.shreg[7:1] != my_addr) |=> !st_ff.sda_oe [*2])
    else $error("Mismatched address drove the data line.");
  a_strap_addr: assert property (@(posedge mclk) disable iff (!arst_n)
    s_addr_end and (st_ff.shreg[7:1] == (sel_s ? 7'h69 : 7'h6e)) |=> st_ff.sda_oe)
    else $error("Strap selected the wrong address.");
  a_cmd_offset: assert property (@(posedge mclk) disable iff (!arst_n)
    st_ff.fsm == smoe_pkg::SMOE_CMD && byte_done && scl_fall && !stop_det && !start_det
    && st_ff.shreg[7] |=> st_ff.sda_oe && st_ff.offset == $past(st_ff.shreg[4:0]))
    else $error("Byte command not acknowledged or offset lost.");
  a_write_commit: assert property (@(posedge mclk) disable iff (!arst_n)
    stop_det && st_ff.wr_pend && st_ff.offset == 5'h16 |=> st_ff.thr_fb == $past(st_ff.wbyte))
    else $error("Written byte not stored at stop.");
  a_read_msb_first: assert property (@(posedge mclk) disable iff (!arst_n)
    st_ff.fsm == smoe_pkg::SMOE_ACK_A && st_ff.rw && scl_fall && !stop_det && !start_det
    |=> st_ff.fsm == smoe_pkg::SMOE_RDATA && st_ff.sda_oe == !$past(rd_byte[7]))
    else $error("Read did not start with the top bit.");
  a_shift_in_order: assert property (@(posedge mclk) disable iff (!arst_n)
    scl_rise && !stop_det && !start_det && st_ff.fsm == smoe_pkg::SMOE_WDATA
    |=> st_ff.shreg[0] == $past(sda_s) && st_ff.cnt == $past(st_ff.cnt) + 4'h1)
    else $error("Serial bit not shifted in at the bottom.");
  a_reset_default: assert property (@(posedge mclk) disable iff (!arst_n)
    !st_ff.touched |-> st_ff.thr_fb == 8'h0f && st_ff.pair_en == 8'hff)
    else $error("Default register contents disturbed.");
  a_output_gates: assert property (@(posedge mclk) disable iff (!arst_n)
    $changed(st_ff.pair_en) |-> clk_ctl.bank_a_pair0_true_en == st_ff.pair_en[2]
    && clk_ctl.bank_b_pair1_comp_en == st_ff.pair_en[7])
    else $error("Pair enables do not follow the register.");
  a_fb_threshold: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_ctl.feedback_out_bank_a_en != st_ff.thr_fb[5]
    && clk_ctl.threshold_sel == st_ff.thr_fb[7:6] && clk_ctl.bank_b_pair2_true_en == st_ff.thr_fb[1])
    else $error("Feedback or threshold outputs wrong.");
endmodule : smoe_top

// *** verif/smoe_host.sv ***
`timescale 1ns/1ps
module smoe_host (
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl,
  output wire logic sda
);
  logic       drv = 1'b1;
  logic [7:0] rd_val;
  logic [2:0] acks;
  event       rd_ev;
  initial scl = 1'b1;
  // The data line has a pull-up, so it reads high unless someone pulls it.
  // The device only wins the wired line while its enable is high.
  assign sda = drv & ~(sda_oe & ~sda_out);
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    #31 scl = 1'b1;
    #31 r = sda;
    #31 scl = 1'b0;
    #32;
  endtask : bit_io
  task automatic start;
    drv = 1'b1;
    #31 scl = 1'b1;
    #31 drv = 1'b0;
    #31 scl = 1'b0;
    #31;
  endtask : start
  task automatic stop;
    drv = 1'b0;
    #31 scl = 1'b1;
    #31 drv = 1'b1;
    #62;
  endtask : stop
  task automatic byte_io(input logic [7:0] d, input logic hack, output logic [7:0] r,
                         output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(hack, a);
  endtask : byte_io
  task automatic wr(input logic [6:0] ad, input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] r;
    start();
    byte_io({ad, 1'b0}, 1'b1, r, acks[0]);
    byte_io(cmd, 1'b1, r, acks[1]);
    byte_io(d, 1'b1, r, acks[2]);
    stop();
  endtask : wr
  task automatic rd(input logic [6:0] ad, input logic [7:0] cmd);
    logic a;
    start();
    byte_io({ad, 1'b0}, 1'b1, rd_val, acks[0]);
    byte_io(cmd, 1'b1, rd_val, acks[1]);
    start();
    byte_io({ad, 1'b1}, 1'b1, rd_val, acks[2]);
    byte_io(8'hff, 1'b0, rd_val, a);
    stop();
    -> rd_ev;
  endtask : rd
endmodule : smoe_host

// *** verif/smoe_top_tb.sv ***
`timescale 1ns/1ps
module smoe_top_tb;
  logic                mclk     = 1'b0;
  logic                arst_n   = 1'b0;
  logic                addr_sel = 1'b1;
  logic [6:0]          me       = 7'h69;
  logic                scl;
  logic                sda;
  logic                sda_out;
  logic                sda_oe;
  smoe_pkg::smoe_out_t clk_ctl;
  logic [7:0]          q[$];
  int                  bad_count = 0;
  int                  checks    = 0;
  int                  seed      = 32'h8be5e08d;
  logic [7:0]          t;
  logic [7:0]          p;
  always #4 mclk = ~mclk;
  smoe_top smoe_top_i (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .scl_in  (scl),
    .sda_in  (sda),
    .addr_sel(addr_sel),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .clk_ctl (clk_ctl)
  );
  smoe_host smoe_host_i (
    .sda_oe (sda_oe),
    .sda_out(sda_out),
    .scl    (scl),
    .sda    (sda)
  );
  function automatic smoe_pkg::smoe_out_t map(input logic [7:0] a, input logic [7:0] b);
    map = {a[7:6], ~a[5], ~a[4], {2{a[1]}}, {2{b[7]}}, {2{b[6]}}, {2{b[5]}}, {2{b[3]}},
           {2{b[2]}}};
  endfunction : map
  task automatic chk(input logic [15:0] exp, input logic [15:0] got, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  always @(smoe_host_i.rd_ev) begin
    chk({8'h00, q.pop_front()}, {8'h00, smoe_host_i.rd_val}, "read data");
  end
  task automatic rd_exp(input logic [7:0] cmd, input logic [7:0] e);
    q.push_back(e);
    smoe_host_i.rd(me, cmd);
    chk(16'h0000, {13'h0, smoe_host_i.acks}, "read acks");
  endtask : rd_exp
  task automatic wr_chk(input logic [7:0] cmd, input logic [7:0] d, input logic [2:0] ea);
    smoe_host_i.wr(me, cmd, d);
    chk({13'h0, ea}, {13'h0, smoe_host_i.acks}, "write acks");
  endtask : wr_chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    // About four times the length of all scenarios together.
    #400000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 arst_n = 1'b1;
    #100;
    chk(16'h3fff, clk_ctl, "defaults");
    rd_exp(8'h96, 8'h0f);
    rd_exp(8'hb7, 8'hff);
    $display("test defaults done");
    smoe_host_i.wr(7'h6e, 8'h96, 8'h00);
    chk(16'h0007, {13'h0, smoe_host_i.acks}, "foreign address");
    chk(16'h3fff, clk_ctl, "foreign write kept out");
    @(posedge mclk);
    #1 addr_sel = 1'b0;
    me = 7'h6e;
    #100;
    rd_exp(8'h97, 8'hff);
    $display("test strap done");
    for (int k = 0; k < 4; k++) begin
      // Reserved bits are written as zero, as a well-behaved host does.
      t = (8'($random(seed)) & 8'h32) | {k[1:0], 6'h00};
      p = 8'($random(seed)) & 8'hec;
      wr_chk({1'b1, k[1:0], 5'h16}, t, 3'b000);
      wr_chk({1'b1, ~k[1:0], 5'h17}, p, 3'b000);
      #100 chk(map(t, p), clk_ctl, "controls");
      rd_exp({3'b101, 5'h16}, t);
      rd_exp(8'h97, p);
    end
    $display("test codes done");
    wr_chk(8'h16, 8'hff, 3'b110);
    wr_chk(8'h85, 8'haa, 3'b000);
    rd_exp(8'h85, 8'h00);
    #100 chk(map(t, p), clk_ctl, "refused kept out");
    $display("test refusals done");
    @(posedge mclk);
    #1 arst_n = 1'b0;
    #20 chk(16'h3fff, clk_ctl, "reset again");
    $display("test reset done");
    complete_run();
  end
endmodule : smoe_top_tb
